// >>> mrio_regs.svh
/*
 * constants of the motor relay i/o control block: register offsets, field
 * positions, reset values and timing counts.
 * assumes a 100 MHz clock and a plain strobe register port.
 */
`ifndef MRIO_REGS_SVH
`define MRIO_REGS_SVH

`define MRIO_CLK_MHZ 100
// register offsets (byte addresses, one word each)
`define MRIO_OFS_CTRL 8'h00
`define MRIO_OFS_ALARM_ASSIGN 8'h04
`define MRIO_OFS_ALARM_COND 8'h08
`define MRIO_OFS_TRIP_COND 8'h0c
`define MRIO_OFS_RTD_CFG 8'h10
`define MRIO_OFS_READINGS 8'h14
`define MRIO_OFS_STATUS 8'h18
`define MRIO_OFS_DAC 8'h1c
`define MRIO_OFS_THERMAL 8'h20
`define MRIO_OFS_STARTS 8'h24
`define MRIO_OFS_PANEL 8'h28
// control fields
`define MRIO_CTRL_TRIP_FS 0
`define MRIO_CTRL_ALARM_FS 1
`define MRIO_CTRL_AUX1_FS 2
`define MRIO_CTRL_ALARM_LATCH 3
`define MRIO_CTRL_AUX1_LATCH 4
`define MRIO_CTRL_SPECIAL_RESET 5
`define MRIO_CTRL_RTD_THERMAL 6
`define MRIO_CTRL_EXTENDED 7
`define MRIO_CTRL_AMBIENT_EN 8
`define MRIO_CTRL_DIFF_TRIP 9
`define MRIO_CTRL_DIFF_AUX1 10
`define MRIO_CTRL_SRC_LSB 12
`define MRIO_CTRL_RESET 32'h0000_0001
// panel register fields (write-one pulses)
`define MRIO_PANEL_RESET_KEY 0
`define MRIO_PANEL_TRIP 1
`define MRIO_PANEL_LOCKOUT_CLR 2
// analog output codes: 16-bit dac, 4 mA = 0x3333, 20 mA = 0xff5c, 20.2 mA = 0xffff
// span is full minus low, so the line meets the full-scale code exactly
`define MRIO_DAC_LOW 16'h3333
`define MRIO_DAC_SPAN 16'hcc29
`define MRIO_DAC_SAT 16'hffff
`define MRIO_DAC_FULL 16'hff5c
// full scale of each reading, in its own unit, then the most stator rtds
`define MRIO_FS_THERMAL 16'h0064
`define MRIO_FS_FLC 16'h0064
`define MRIO_FS_STATOR 16'h00c8
`define MRIO_FS_SECONDARY 16'h0064
`define MRIO_STATOR_MAX 6
// timing
`define MRIO_DEBOUNCE_MS 10
`define MRIO_DEBOUNCE_CYC (`MRIO_DEBOUNCE_MS * 1000 * `MRIO_CLK_MHZ)
`define MRIO_HOLD_S 11
`define MRIO_HOLD_CYC (`MRIO_HOLD_S * 1000000 * `MRIO_CLK_MHZ)

`endif

// >>> mrio_pkg.sv
/*
 * types of the motor relay i/o control block.
 * assumes mrio_regs.svh for the numbers.
 */
package mrio_pkg;
   typedef enum logic [1:0] {
      MRIO_SRC_THERMAL,
      MRIO_SRC_FLC,
      MRIO_SRC_STATOR,
      MRIO_SRC_SECONDARY
   } mrio_src_e;

   // coil drive of the four output relays, high energises the coil
   typedef struct packed {
      logic trip;
      logic alarm;
      logic aux1;
      logic aux2;
   } mrio_coil_s;

   // debounced contact inputs
   typedef struct packed {
      logic restart;
      logic ext_reset;
      logic diff;
   } mrio_contact_s;
endpackage : mrio_pkg

// >>> mrio_debounce.sv
/*
 * one contact debouncer with two-flop synchroniser.
 * assumes a raw pin from outside the clock domain.
 */
`timescale 1ns/1ps

module mrio_debounce #(
   parameter int COUNT = 1000000
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic level
);
   logic sync1_reg;
   logic sync2_reg;
   logic [31:0] cnt_reg;
   wire differs = sync2_reg != level;
   wire settled = cnt_reg >= 32'(COUNT - 1);

   // two flops, the first read only by the second
   always_ff @(posedge clk)
   begin
      sync1_reg <= reset ? 1'b0 : pin;
      sync2_reg <= reset ? 1'b0 : sync1_reg;
   end

   // level changes only after the pin stays changed COUNT cycles
   always_ff @(posedge clk)
   begin
      if (reset || !differs)
      begin
         cnt_reg <= 32'h0;
         level <= reset ? 1'b0 : level;
      end
      else if (settled)
      begin
         cnt_reg <= 32'h0;
         level <= sync2_reg;
      end
      else
         cnt_reg <= cnt_reg + 32'h1;
   end
endmodule : mrio_debounce

// >>> mrio_top.sv
/*
 * output relay and contact input control of a motor protection relay:
 * relay coil drive, rtd roles, emergency restart, external reset, analog
 * output scaling and differential contact input.
 * assumes contacts on pins, readings and conditions from the protection
 * firmware via the register port, a 100 MHz clock.
 */
// Notes on behaviour
// R1 - second auxiliary relay is always latched and fail-safe, not settable.
// R2 - any alarm combination may energise aux two, assigned like alarm relay.
// R3 - fail-safe relay coil drops out when activated or on power loss.
// R4 - factory: trip fail-safe, alarm and aux one non-fail-safe, aux two fail-safe.
// R5 - up to six rtds are stator; programmed count picks lowest inputs.
// R6 - highest rtd (eight basic, ten extended) may be ambient sensor.
// R7 - learn cooling times only with stator rtds, else preset values.
// R8 - restart closure clears thermal memory to zero percent.
// R9 - with rtd thermal input, clear only after closure held over 11 s.
// R10 - each restart closure decrements starts-per-hour count by one.
// R11 - no trip reset during lock-out; lock-out timing keeps running.
// R12 - external reset closure acts like the panel reset key.
// R13 - special reset: panel key leaves aux one, external reset clears it.
// R14 - external reset held closed resets whenever conditions allow.
// R15 - analog output from one selectable source, changeable any time.
// R16 - 4 mA at low scale, 20 mA at full scale.
// R17 - above full scale output saturates at 20.2 mA.
// R18 - linear scaling between low and full scale.
// R19 - differential closure at once activates its assigned relay.
// R20 - reset after differential trip only when contact open again.
// R21 - contact inputs debounced so one closure gives one event.
`timescale 1ns/1ps
`include "mrio_regs.svh"

module mrio_top #(
   parameter int DEBOUNCE_CYC = `MRIO_DEBOUNCE_CYC,
   parameter int HOLD_CYC = `MRIO_HOLD_CYC,
   parameter int RTD_BASIC = 8,
   parameter int RTD_EXT = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic restart_pin,
   input wire logic ext_reset_pin,
   input wire logic diff_pin,
   output mrio_pkg::mrio_coil_s coil,
   output logic [15:0] dac_code,
   output logic [9:0] stator_mask,
   output logic [9:0] ambient_mask,
   output logic learn_cooling,
   output logic thermal_clear,
   output logic starts_dec
);
   ////////////////////////////////////////////////////////////////////////
   // contact inputs
   mrio_pkg::mrio_contact_s cin;
   logic restart_prev_reg;
   logic ext_prev_reg;

   mrio_debounce #(.COUNT(DEBOUNCE_CYC)) u_db_restart (
      .clk(clk),
      .reset(reset),
      .pin(restart_pin),
      .level(cin.restart)
   ); // R21
   mrio_debounce #(.COUNT(DEBOUNCE_CYC)) u_db_ext (
      .clk(clk),
      .reset(reset),
      .pin(ext_reset_pin),
      .level(cin.ext_reset)
   ); // R21
   mrio_debounce #(.COUNT(DEBOUNCE_CYC)) u_db_diff (
      .clk(clk),
      .reset(reset),
      .pin(diff_pin),
      .level(cin.diff)
   ); // R21

   // edge detection of debounced levels
   always_ff @(posedge clk)
   begin
      restart_prev_reg <= reset ? 1'b0 : cin.restart;
      ext_prev_reg <= reset ? 1'b0 : cin.ext_reset;
   end
   wire restart_rise = cin.restart && !restart_prev_reg;
   wire ext_rise = cin.ext_reset && !ext_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // registers written by software
   logic [31:0] ctrl_reg;
   logic [31:0] alarm_assign_reg;
   logic [31:0] alarm_cond_reg;
   logic [31:0] trip_cond_reg;
   logic [31:0] rtd_cfg_reg;
   logic [31:0] readings_reg;
   logic lockout_reg;

   wire wr_ctrl = wr && addr == `MRIO_OFS_CTRL;
   wire wr_assign = wr && addr == `MRIO_OFS_ALARM_ASSIGN;
   wire wr_acond = wr && addr == `MRIO_OFS_ALARM_COND;
   wire wr_tcond = wr && addr == `MRIO_OFS_TRIP_COND;
   wire wr_rtd = wr && addr == `MRIO_OFS_RTD_CFG;
   wire wr_read = wr && addr == `MRIO_OFS_READINGS;
   wire wr_panel = wr && addr == `MRIO_OFS_PANEL;
   wire key_press = wr_panel && wdata[`MRIO_PANEL_RESET_KEY];
   wire fw_trip = wr_panel && wdata[`MRIO_PANEL_TRIP];
   wire lock_clr = wr_panel && wdata[`MRIO_PANEL_LOCKOUT_CLR];

   // configuration; reset gives factory relay modes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_reg <= `MRIO_CTRL_RESET; // R4
         alarm_assign_reg <= 32'h0;
         alarm_cond_reg <= 32'h0;
         trip_cond_reg <= 32'h0;
         rtd_cfg_reg <= 32'h0;
         readings_reg <= 32'h0;
      end
      else
      begin
         ctrl_reg <= wr_ctrl ? wdata : ctrl_reg;
         alarm_assign_reg <= wr_assign ? wdata : alarm_assign_reg;
         alarm_cond_reg <= wr_acond ? wdata : alarm_cond_reg;
         trip_cond_reg <= wr_tcond ? wdata : trip_cond_reg;
         rtd_cfg_reg <= wr_rtd ? wdata : rtd_cfg_reg;
         readings_reg <= wr_read ? wdata : readings_reg;
      end
   end

   // lock-out flag: set by firmware bit 16 of trip cond write, cleared on
   // timer expiry; timing lives in firmware so it survives power loss
   always_ff @(posedge clk)
   begin
      if (reset)
         lockout_reg <= 1'b0;
      else if (wr_tcond && wdata[16])
         lockout_reg <= 1'b1; // set wins over clear
      else if (lock_clr)
         lockout_reg <= 1'b0; // R11
   end

   ////////////////////////////////////////////////////////////////////////
   // relay logic
   logic trip_act_reg;
   logic alarm_act_reg;
   logic aux1_act_reg;
   logic aux2_act_reg;
   logic diff_trip_reg;

   wire alarm_any = |alarm_cond_reg;
   wire aux2_req = |(alarm_cond_reg & alarm_assign_reg); // R2
   wire trip_req = (|trip_cond_reg[15:0]) || fw_trip;
   wire diff_to_trip = cin.diff && ctrl_reg[`MRIO_CTRL_DIFF_TRIP]; // R19
   wire diff_to_aux1 = cin.diff && ctrl_reg[`MRIO_CTRL_DIFF_AUX1]; // R19
   // a reset request: key, external edge, or external held closed
   wire ext_req = ext_rise || cin.ext_reset; // R12 R14
   wire reset_ok = !lockout_reg && !cin.diff; // R11 R20
   wire do_reset = (key_press || ext_req) && reset_ok;
   wire aux1_reset = (ext_req || (key_press && !ctrl_reg[`MRIO_CTRL_SPECIAL_RESET]))
      && reset_ok; // R13

   // trip latched until reset; differential activates without delay
   always_ff @(posedge clk)
   begin
      if (reset)
         trip_act_reg <= 1'b0;
      else
         trip_act_reg <= trip_req || diff_to_trip || (trip_act_reg && !do_reset);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         diff_trip_reg <= 1'b0;
      else
         diff_trip_reg <= cin.diff || (diff_trip_reg && !do_reset); // R20
   end

   // alarm and aux one latch only when set so
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         alarm_act_reg <= 1'b0;
         aux1_act_reg <= 1'b0;
      end
      else
      begin
         alarm_act_reg <= alarm_any ||
            (ctrl_reg[`MRIO_CTRL_ALARM_LATCH] && alarm_act_reg && !do_reset);
         aux1_act_reg <= diff_to_aux1 ||
            (ctrl_reg[`MRIO_CTRL_AUX1_LATCH] && aux1_act_reg && !aux1_reset);
      end
   end

   // aux two is always latched, no control bit reaches it
   always_ff @(posedge clk)
   begin
      if (reset)
         aux2_act_reg <= 1'b0;
      else
         aux2_act_reg <= aux2_req || (aux2_act_reg && !do_reset); // R1
   end

   // coil drive: fail-safe coils sit energised and drop on activation, so
   // loss of power gives the same contact state
   always_ff @(posedge clk)
   begin
      if (reset)
         coil <= '0;
      else
      begin
         coil.trip <= trip_act_reg ^ ctrl_reg[`MRIO_CTRL_TRIP_FS]; // R3
         coil.alarm <= alarm_act_reg ^ ctrl_reg[`MRIO_CTRL_ALARM_FS]; // R3
         coil.aux1 <= aux1_act_reg ^ ctrl_reg[`MRIO_CTRL_AUX1_FS]; // R3
         coil.aux2 <= !aux2_act_reg; // R1 R3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rtd roles
   wire [2:0] stator_cnt_raw = rtd_cfg_reg[2:0];
   wire [2:0] stator_cnt = (stator_cnt_raw > 3'(`MRIO_STATOR_MAX))
      ? 3'(`MRIO_STATOR_MAX) : stator_cnt_raw; // R5
   wire [9:0] stator_sel = 10'((11'h1 << stator_cnt) - 11'h1); // R5
   wire [3:0] ambient_idx = ctrl_reg[`MRIO_CTRL_EXTENDED]
      ? 4'(RTD_EXT - 1) : 4'(RTD_BASIC - 1); // R6
   wire [9:0] ambient_sel = ctrl_reg[`MRIO_CTRL_AMBIENT_EN]
      ? 10'(11'h1 << ambient_idx) : 10'h0; // R6

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         stator_mask <= 10'h0;
         ambient_mask <= 10'h0;
         learn_cooling <= 1'b0;
      end
      else
      begin
         stator_mask <= stator_sel & ~ambient_sel;
         ambient_mask <= ambient_sel;
         learn_cooling <= stator_cnt != 3'h0; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // emergency restart
   logic [31:0] hold_cnt_reg;
   logic hold_done_reg;
   wire hold_expired = hold_cnt_reg >= 32'(HOLD_CYC - 1);
   wire rtd_thermal = ctrl_reg[`MRIO_CTRL_RTD_THERMAL];

   // hold timer only used when rtd input feeds thermal memory
   always_ff @(posedge clk)
   begin
      if (reset || !cin.restart)
      begin
         hold_cnt_reg <= 32'h0;
         hold_done_reg <= 1'b0;
      end
      else if (!hold_done_reg)
      begin
         hold_cnt_reg <= hold_cnt_reg + 32'h1;
         hold_done_reg <= hold_expired; // R9
      end
   end
   wire hold_fire = cin.restart && !hold_done_reg && hold_expired;

   // one pulse each for thermal clear and starts decrement
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         thermal_clear <= 1'b0;
         starts_dec <= 1'b0;
      end
      else
      begin
         thermal_clear <= rtd_thermal ? hold_fire : restart_rise; // R8 R9
         starts_dec <= restart_rise; // R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog output
   function automatic logic [15:0] mrio_scale(input logic [15:0] val,
                                              input logic [15:0] fs);
      logic [31:0] prod;
      prod = 32'(val) * 32'(`MRIO_DAC_SPAN);
      if (val > fs)
         mrio_scale = `MRIO_DAC_SAT; // R17
      else if (val == fs)
         mrio_scale = `MRIO_DAC_FULL; // R16
      else
         mrio_scale = 16'(`MRIO_DAC_LOW + 16'(prod / 32'(fs))); // R16 R18
   endfunction : mrio_scale

   mrio_pkg::mrio_src_e src;
   assign src = mrio_pkg::mrio_src_e'(ctrl_reg[`MRIO_CTRL_SRC_LSB +: 2]);
   wire [15:0] rd_lo = readings_reg[15:0];
   wire [15:0] rd_hi = readings_reg[31:16];
   logic [15:0] dac_next;

   // readings: low half thermal or stator, high half flc or secondary
   always_comb
   begin
      unique case (src) // R15
         mrio_pkg::MRIO_SRC_THERMAL: dac_next = mrio_scale(rd_lo, `MRIO_FS_THERMAL);
         mrio_pkg::MRIO_SRC_FLC: dac_next = mrio_scale(rd_hi, `MRIO_FS_FLC);
         mrio_pkg::MRIO_SRC_STATOR: dac_next = mrio_scale(rd_lo, `MRIO_FS_STATOR);
         mrio_pkg::MRIO_SRC_SECONDARY: dac_next = mrio_scale(rd_hi, `MRIO_FS_SECONDARY);
      endcase
   end

   always_ff @(posedge clk)
   begin
      dac_code <= reset ? `MRIO_DAC_LOW : dac_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // register read
   wire [31:0] status_word = {21'h0, diff_trip_reg, lockout_reg,
      cin.restart, cin.ext_reset, cin.diff, trip_act_reg, alarm_act_reg,
      aux1_act_reg, aux2_act_reg, learn_cooling, 1'b0};
   logic [31:0] rd_mux;

   always_comb
   begin
      unique case (addr)
         `MRIO_OFS_CTRL: rd_mux = ctrl_reg;
         `MRIO_OFS_ALARM_ASSIGN: rd_mux = alarm_assign_reg;
         `MRIO_OFS_ALARM_COND: rd_mux = alarm_cond_reg;
         `MRIO_OFS_TRIP_COND: rd_mux = trip_cond_reg;
         `MRIO_OFS_RTD_CFG: rd_mux = rtd_cfg_reg;
         `MRIO_OFS_READINGS: rd_mux = readings_reg;
         `MRIO_OFS_STATUS: rd_mux = status_word;
         `MRIO_OFS_DAC: rd_mux = {16'h0, dac_code};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      rdata <= (reset || !rd) ? 32'h0 : rd_mux;
   end
endmodule : mrio_top

// >>> mrio_top_props.sv
/* port checks for the motor relay i/o block.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps

module mrio_top_props #(
   parameter int DEBOUNCE_CYC = 4,
   parameter int HOLD_CYC = 20,
   parameter int RTD_BASIC = 8,
   parameter int RTD_EXT = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic restart_pin,
   input wire logic ext_reset_pin,
   input wire logic diff_pin,
   input wire mrio_pkg::mrio_coil_s coil,
   input wire logic [15:0] dac_code,
   input wire logic [9:0] stator_mask,
   input wire logic [9:0] ambient_mask,
   input wire logic learn_cooling,
   input wire logic thermal_clear,
   input wire logic starts_dec
);
   int hi_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // cycles the raw restart contact has stayed closed, saturating
   always_ff @(posedge clk)
   begin
      if (reset || !restart_pin)
         hi_cnt <= 0;
      else if (hi_cnt < 1000)
         hi_cnt <= hi_cnt + 1;
   end
   ////////////////////////////////////////
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside read slot");
   AST_DAC_FLOOR: assert property (dac_code >= 16'h3333)
      else $error("analog code below low scale");
   AST_STATOR_LIMIT: assert property (stator_mask[9:6] == 4'h0)
      else $error("stator role beyond six inputs");
   AST_STATOR_LOW: assert property (((stator_mask + 10'h1) & stator_mask) == 10'h0)
      else $error("stator inputs not the lowest ones");
   AST_AMBIENT: assert property (ambient_mask == 10'h0 || ambient_mask == 10'(1 << (RTD_BASIC - 1)) || ambient_mask == 10'(1 << (RTD_EXT - 1)))
      else $error("ambient role on wrong input");
   AST_LEARN: assert property ((stator_mask == 10'h0) [*2] |-> !learn_cooling)
      else $error("learning without stator inputs");
   AST_STARTS_ONE: assert property (starts_dec |=> !starts_dec)
      else $error("starts decrement longer than one cycle");
   AST_CLEAR_ONE: assert property (thermal_clear |=> !thermal_clear)
      else $error("thermal clear longer than one cycle");
   AST_STARTS_DEB: assert property (starts_dec |-> hi_cnt >= DEBOUNCE_CYC)
      else $error("starts decrement before debounce");
   AST_CLEAR_DEB: assert property (thermal_clear |-> hi_cnt >= DEBOUNCE_CYC)
      else $error("thermal clear before debounce");
endmodule : mrio_top_props

bind mrio_top mrio_top_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .HOLD_CYC(HOLD_CYC),
   .RTD_BASIC(RTD_BASIC), .RTD_EXT(RTD_EXT)) mrio_top_props_inst (.clk(clk),
   .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .restart_pin(restart_pin), .ext_reset_pin(ext_reset_pin), .diff_pin(diff_pin),
   .coil(coil), .dac_code(dac_code), .stator_mask(stator_mask),
   .ambient_mask(ambient_mask), .learn_cooling(learn_cooling),
   .thermal_clear(thermal_clear), .starts_dec(starts_dec));

// >>> mrio_contacts.sv
/* behavioural switch contacts on the restart, external reset and
   differential terminals. assumes the bench commands each closure. */
`timescale 1ns/1ps

module mrio_contacts (
   input wire logic clk,
   input wire logic [2:0] close_cmd,
   output logic [2:0] pin
);
   logic [2:0] last_reg;
   logic [2:0] chg_reg;
   logic [1:0] bounce_reg;
   initial
   begin
      pin = 3'h0;
      last_reg = 3'h0;
      chg_reg = 3'h0;
      bounce_reg = 2'h0;
   end
   // real contacts chatter for a few cycles after every change
   always @(posedge clk)
   begin
      last_reg <= close_cmd;
      if (close_cmd != last_reg)
      begin
         bounce_reg <= 2'h3;
         chg_reg <= close_cmd ^ last_reg;
         pin <= pin ^ (close_cmd ^ last_reg);
      end
      else if (bounce_reg != 2'h0)
      begin
         bounce_reg <= bounce_reg - 2'h1;
         pin <= (bounce_reg == 2'h1) ? close_cmd : pin ^ chg_reg;
      end
      else
         pin <= close_cmd;
   end
endmodule : mrio_contacts

// >>> testbench.sv
/* self-checking bench of the motor relay i/o block with short counts.
   assumes the contact model and the bound port checker. */
`timescale 1ns/1ps
`include "mrio_regs.svh"

module testbench;
   logic clk, reset, wr, rd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, seed;
   logic [2:0] close_cmd, pin;
   mrio_pkg::mrio_coil_s coil;
   logic [15:0] dac_code, v;
   logic [9:0] stator_mask, ambient_mask;
   logic learn_cooling, thermal_clear, starts_dec;
   int failures, tests_run;
   logic [15:0] fs_t [4] = '{`MRIO_FS_THERMAL, `MRIO_FS_FLC, `MRIO_FS_STATOR, `MRIO_FS_SECONDARY};

   mrio_top #(.DEBOUNCE_CYC(4), .HOLD_CYC(20), .RTD_BASIC(8), .RTD_EXT(10)) mrio_top_inst (
      .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .restart_pin(pin[2]), .ext_reset_pin(pin[1]), .diff_pin(pin[0]),
      .coil(coil), .dac_code(dac_code), .stator_mask(stator_mask),
      .ambient_mask(ambient_mask), .learn_cooling(learn_cooling),
      .thermal_clear(thermal_clear), .starts_dec(starts_dec));
   mrio_contacts mrio_contacts_inst (.clk(clk), .close_cmd(close_cmd), .pin(pin));
   ////////////////////////////////////////
   always #5 clk = ~clk;
   // a hang counts as a mismatch
   initial
   begin
      #200000;
      failures = failures + 1;
      conclude();
   end
   ////////////////////////////////////////
   task automatic conclude();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   // one-cycle write, then time for the coils to follow
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      idle(2);
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : reg_read
   task automatic contact(input int b, input logic c);
      @(posedge clk);
      close_cmd[b] <= c;
      idle(16);
   endtask : contact
   // hold a contact closed and count the pulses it causes, during the hold and after release
   task automatic press(input int b, input int hold, input int es, input int ec);
      int ns, nc;
      ns = 0;
      nc = 0;
      @(posedge clk);
      close_cmd[b] <= 1'b1;
      repeat (hold + 24)
      begin
         @(posedge clk);
         if (hold == 0)
            close_cmd[b] <= 1'b0;
         hold = hold - 1;
         #1;
         ns = ns + int'(starts_dec === 1'b1);
         nc = nc + int'(thermal_clear === 1'b1);
      end
      chk(ns, es);
      chk(nc, ec);
   endtask : press
   function automatic logic [15:0] dac_exp(input logic [1:0] s, input logic [15:0] val);
      logic [31:0] f;
      f = {16'h0, fs_t[s]};
      if (val > f)
         return `MRIO_DAC_SAT;
      if (val == f)
         return `MRIO_DAC_FULL;
      return 16'(32'(`MRIO_DAC_LOW) + 32'(val) * 32'(`MRIO_DAC_SPAN) / f);
   endfunction : dac_exp
   ////////////////////////////////////////
   initial
   begin
      clk = 0; reset = 1; wr = 0; rd = 0; addr = 0; wdata = 0; close_cmd = 0;
      failures = 0; tests_run = 0; seed = 32'h3eb5;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      reg_read(`MRIO_OFS_CTRL, `MRIO_CTRL_RESET);
      chk(32'(coil), 32'h9);
      reg_read(8'h24, 32'h0);
      // aux two follows only its assigned alarms and stays latched
      reg_write(`MRIO_OFS_ALARM_ASSIGN, 32'h5);
      reg_write(`MRIO_OFS_ALARM_COND, 32'h2);
      chk(32'(coil), 32'hd);
      reg_write(`MRIO_OFS_ALARM_COND, 32'h4);
      chk(32'(coil), 32'hc);
      reg_write(`MRIO_OFS_ALARM_COND, 32'h0);
      chk(32'(coil), 32'h8);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil), 32'h9);
      // fail-safe alarm and aux one sit energised, latched alarm holds
      reg_write(`MRIO_OFS_CTRL, 32'h00f);
      chk(32'(coil), 32'hf);
      reg_write(`MRIO_OFS_ALARM_COND, 32'h1);
      chk(32'(coil), 32'ha);
      reg_write(`MRIO_OFS_ALARM_COND, 32'h0);
      chk(32'(coil), 32'ha);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil), 32'hf);
      // differential trip, refused reset while closed, operator opens
      reg_write(`MRIO_OFS_CTRL, 32'h201);
      contact(0, 1'b1);
      chk(32'(coil.trip), 32'h0);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil.trip), 32'h0);
      contact(0, 1'b0);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil.trip), 32'h1);
      // lock-out blocks the reset key until cleared
      reg_write(`MRIO_OFS_TRIP_COND, 32'h1_0001);
      reg_write(`MRIO_OFS_TRIP_COND, 32'h0);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil.trip), 32'h0);
      reg_write(`MRIO_OFS_PANEL, 32'h4);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil.trip), 32'h1);
      // external reset held closed clears a trip once its cause is gone
      contact(1, 1'b1);
      reg_write(`MRIO_OFS_TRIP_COND, 32'h1);
      chk(32'(coil.trip), 32'h0);
      reg_write(`MRIO_OFS_TRIP_COND, 32'h0);
      idle(2);
      chk(32'(coil.trip), 32'h1);
      contact(1, 1'b0);
      // special reset: key spares aux one, external contact clears it
      reg_write(`MRIO_OFS_CTRL, 32'h431);
      contact(0, 1'b1);
      chk(32'(coil.aux1), 32'h1);
      contact(0, 1'b0);
      reg_write(`MRIO_OFS_PANEL, 32'h1);
      chk(32'(coil.aux1), 32'h1);
      press(1, 20, 0, 0);
      chk(32'(coil.aux1), 32'h0);
      // stator count including the value 7 above the clamp
      for (int c = 0; c < 8; c++)
      begin
         reg_write(`MRIO_OFS_RTD_CFG, 32'(c));
         chk(32'(stator_mask), 32'((10'h1 << (c > 6 ? 6 : c)) - 10'h1));
         chk(32'(learn_cooling), 32'(c != 0));
      end
      reg_write(`MRIO_OFS_CTRL, 32'h101);
      chk(32'(ambient_mask), 32'h80);
      reg_write(`MRIO_OFS_CTRL, 32'h181);
      chk(32'(ambient_mask), 32'h200);
      // every analog source, full scale and just above it first
      for (int i = 0; i < 16; i++)
      begin
         v = 16'($unsigned($random(seed)) % 230);
         if (i < 4)
            v = fs_t[i[1:0]];
         else if (i < 8)
            v = fs_t[i[1:0]] + 16'h1;
         reg_write(`MRIO_OFS_READINGS, {v, v});
         reg_write(`MRIO_OFS_CTRL, 32'h1 | (32'(i[1:0]) << `MRIO_CTRL_SRC_LSB));
         chk(32'(dac_code), 32'(dac_exp(i[1:0], v)));
      end
      // restart: one decrement per closure, clear waits when rtd feeds memory
      press(2, 40, 1, 1);
      reg_write(`MRIO_OFS_CTRL, 32'h41);
      press(2, 60, 1, 1);
      press(2, 18, 1, 0);
      conclude();
   end
endmodule : testbench
